/* File: core/src_map.svh */
`ifndef SRC_MAP_SVH
`define SRC_MAP_SVH
// ------------------------------------------------------------
// Line timing
// ------------------------------------------------------------
`define SRC_CLK_HZ        250000000
`define SRC_BAUD          115200
`define SRC_BIT_CYC       ((`SRC_CLK_HZ + `SRC_BAUD / 2) / `SRC_BAUD)
// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define SRC_HDR_LEN       16
`define SRC_CRC_H_FIRST   6
`define SRC_CRC_H_LAST    15
`define SRC_ADDR_LEN      8
`define SRC_MAX_DATA      8
`define SRC_RX_BUF_LEN    32
`define SRC_TX_BUF_LEN    24
`define SRC_RD_PAY_LEN    16'h000C
`define SRC_WR_ACK_LEN    4
// ------------------------------------------------------------
// Field values
// ------------------------------------------------------------
`define SRC_PFX0          8'h01
`define SRC_PFX1          8'h00
`define SRC_FLAG_ACK      8'h40
`define SRC_FLAG_NOACK    8'h00
`define SRC_FLAG_LO       8'h01
`define SRC_CMD_HI        8'h08
`define SRC_CMD_RD        8'h00
`define SRC_CMD_RD_ACK    8'h01
`define SRC_CMD_WR        8'h02
`define SRC_CMD_WR_ACK    8'h03
`define SRC_CRC_POLY      16'h1021
`define SRC_CRC_INIT      16'hFFFF
`endif

/* File: core/src_pkg.sv */
package src_pkg;
    typedef logic [7:0] src_byte_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} src_rx_e;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} src_tx_e;
    typedef enum {M_HDR, M_EVAL, M_REQ, M_BUILD, M_CRC, M_SEND} src_main_e;

    function automatic logic [15:0] src_crc_step(input logic [15:0] c, input src_byte_t d,
                                                 input logic [15:0] poly);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ({r[14:0], 1'b0} ^ poly) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : src_crc_step
endpackage : src_pkg

/* File: core/src_core.sv */
`include "src_map.svh"
// Overview of operation
// [R1] Serial line 115200 baud, 8 bits, no parity
// [R2] Only answers; never sends unprompted
// [R3] Frame is 16-byte header plus payload
// [R4] Header multi-byte fields most significant first
// [R5] Header starts with prefix 0x01, 0x00
// [R6] Bytes 2-3: CRC over bytes 6..15
// [R7] Bytes 4-5: CRC from byte 6 to end
// [R8] Channel id bytes 6-7 are zero
// [R9] Reply only when flag 0x40,0x01 requests it
// [R10] Reply flags are 0x00, 0x00
// [R11] Host reads with 0x0800, writes with 0x0802
// [R12] Reply command 0x0801 for read, 0x0803 write
// [R13] Bytes 12-13 give payload length
// [R14] Host increments sequence id per command
// [R15] Reply copies request sequence id
// [R16] Address and length fields are big-endian
// [R17] Read request payload: address, zeros, length
// [R18] Read reply payload is just the data
// [R19] Write request payload: address then data
// [R20] Write reply payload is four zero bytes
// [R21] Drop frames with bad prefix or CRC
module src_core
    import src_pkg::*;
#(
    parameter logic [15:0] CRC_POLY = `SRC_CRC_POLY,
    parameter logic [15:0] CRC_INIT = `SRC_CRC_INIT,
    // Clocks per bit; a bench may shorten it to keep runs brief
    parameter int          BIT_CYC  = `SRC_BIT_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        uart_rxd,
    output logic             uart_txd,
    output logic             reg_req,
    output logic             reg_write,
    output logic [63:0]      reg_addr,
    output logic [63:0]      reg_wdata,
    output logic [15:0]      reg_len,
    input  wire logic        reg_ack,
    input  wire logic [63:0] reg_rdata
);
    localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
    localparam logic [11:0] BIT_HALF = 12'(BIT_CYC / 2);

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    src_rx_e     rx_state_reg, rx_state_next;
    logic [11:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0]  rx_bit_reg, rx_bit_next;
    src_byte_t   rx_sh_reg, rx_sh_next;
    logic        rx_valid_reg, rx_valid_next;
    src_byte_t   rx_byte_reg, rx_byte_next;

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_cnt_next   = rx_cnt_reg + 12'h001;
        rx_bit_next   = rx_bit_reg;
        rx_sh_next    = rx_sh_reg;
        rx_valid_next = 1'b0;
        rx_byte_next  = rx_byte_reg;
        unique case (rx_state_reg)
            RX_IDLE:
            begin
                rx_cnt_next = 12'h000;
                if (!uart_rxd)
                    rx_state_next = RX_START;
            end
            RX_START:
                if (rx_cnt_reg == BIT_HALF)
                begin
                    rx_cnt_next   = 12'h000;
                    rx_bit_next   = 3'h0;
                    // Glitch shorter than half a bit is not a start
                    rx_state_next = uart_rxd ? RX_IDLE : RX_DATA;
                end
            RX_DATA:
                if (rx_cnt_reg == BIT_LAST)
                begin
                    rx_cnt_next = 12'h000;
                    rx_sh_next  = {uart_rxd, rx_sh_reg[7:1]}; // [R1]
                    rx_bit_next = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == 3'h7)
                        rx_state_next = RX_STOP;
                end
            RX_STOP:
                if (rx_cnt_reg == BIT_LAST)
                begin
                    // Framing error: byte dropped, no parity to check
                    rx_valid_next = uart_rxd;
                    rx_byte_next  = rx_sh_reg;
                    rx_state_next = RX_IDLE;
                end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 12'h000;
            rx_bit_reg   <= 3'h0;
            rx_sh_reg    <= 8'h00;
            rx_valid_reg <= 1'b0;
            rx_byte_reg  <= 8'h00;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_bit_reg   <= rx_bit_next;
            rx_sh_reg    <= rx_sh_next;
            rx_valid_reg <= rx_valid_next;
            rx_byte_reg  <= rx_byte_next;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    src_tx_e     tx_state_reg, tx_state_next;
    logic [11:0] tx_cnt_reg, tx_cnt_next;
    logic [2:0]  tx_bit_reg, tx_bit_next;
    src_byte_t   tx_sh_reg, tx_sh_next;
    logic        uart_txd_reg, uart_txd_next;
    logic        tx_go_reg, tx_go_next;
    src_byte_t   tx_data_reg, tx_data_next;

    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_cnt_next   = tx_cnt_reg + 12'h001;
        tx_bit_next   = tx_bit_reg;
        tx_sh_next    = tx_sh_reg;
        uart_txd_next = uart_txd_reg;
        unique case (tx_state_reg)
            TX_IDLE:
            begin
                tx_cnt_next   = 12'h000;
                uart_txd_next = 1'b1;
                if (tx_go_reg)
                begin
                    tx_sh_next    = tx_data_reg;
                    uart_txd_next = 1'b0;
                    tx_state_next = TX_START;
                end
            end
            TX_START:
                if (tx_cnt_reg == BIT_LAST)
                begin
                    tx_cnt_next   = 12'h000;
                    tx_bit_next   = 3'h0;
                    uart_txd_next = tx_sh_reg[0];
                    tx_state_next = TX_DATA;
                end
            TX_DATA:
                if (tx_cnt_reg == BIT_LAST)
                begin
                    tx_cnt_next = 12'h000;
                    tx_bit_next = tx_bit_reg + 3'h1;
                    tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
                    if (tx_bit_reg == 3'h7) // [R1]
                    begin
                        uart_txd_next = 1'b1;
                        tx_state_next = TX_STOP;
                    end
                    else
                        uart_txd_next = tx_sh_reg[1];
                end
            TX_STOP:
                if (tx_cnt_reg == BIT_LAST)
                    tx_state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 12'h000;
            tx_bit_reg   <= 3'h0;
            tx_sh_reg    <= 8'h00;
            uart_txd_reg <= 1'b1;
        end
        else
        begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_bit_reg   <= tx_bit_next;
            tx_sh_reg    <= tx_sh_next;
            uart_txd_reg <= uart_txd_next;
        end
    end

    assign uart_txd = uart_txd_reg;

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    src_main_e   state_reg, state_next;
    logic [16:0] idx_reg, idx_next;
    logic [15:0] crc_h_reg, crc_h_next;
    logic [15:0] crc_t_reg, crc_t_next;
    src_byte_t   rx_buf_reg [`SRC_RX_BUF_LEN];
    src_byte_t   rx_buf_next [`SRC_RX_BUF_LEN];
    src_byte_t   tx_buf_reg [`SRC_TX_BUF_LEN];
    src_byte_t   tx_buf_next [`SRC_TX_BUF_LEN];
    logic        reg_req_reg, reg_req_next;
    logic        reg_write_reg, reg_write_next;
    logic [63:0] reg_addr_reg, reg_addr_next;
    logic [63:0] reg_wdata_reg, reg_wdata_next;
    logic [15:0] reg_len_reg, reg_len_next;
    logic [63:0] rdata_reg, rdata_next;
    logic        want_reg, want_next;
    logic [4:0]  tlen_reg, tlen_next;
    logic [15:0] plen, rlen;
    logic        hdr_ok, rd_ok, wr_ok;

    assign plen   = {rx_buf_reg[12], rx_buf_reg[13]}; // [R13] [R4]
    assign rlen   = {rx_buf_reg[26], rx_buf_reg[27]}; // [R16]
    assign hdr_ok = ({rx_buf_reg[2], rx_buf_reg[3]} == crc_h_reg)                    // [R6] [R21]
                  && ({rx_buf_reg[4], rx_buf_reg[5]} == crc_t_reg)                   // [R7] [R21]
                  && (rx_buf_reg[6] == 8'h00) && (rx_buf_reg[7] == 8'h00)            // [R8]
                  && ((rx_buf_reg[8] == `SRC_FLAG_ACK) || (rx_buf_reg[8] == `SRC_FLAG_NOACK))
                  && (rx_buf_reg[9] == `SRC_FLAG_LO) && (rx_buf_reg[10] == `SRC_CMD_HI);
    assign rd_ok  = (rx_buf_reg[11] == `SRC_CMD_RD) && (plen == `SRC_RD_PAY_LEN)    // [R17]
                  && (rx_buf_reg[24] == 8'h00) && (rx_buf_reg[25] == 8'h00)
                  && (rlen != 16'h0000) && (rlen <= 16'(`SRC_MAX_DATA));
    assign wr_ok  = (rx_buf_reg[11] == `SRC_CMD_WR) && (plen > 16'(`SRC_ADDR_LEN))  // [R19]
                  && (plen <= 16'(`SRC_ADDR_LEN + `SRC_MAX_DATA));

    always_comb
    begin
        state_next     = state_reg;
        idx_next       = idx_reg;
        crc_h_next     = crc_h_reg;
        crc_t_next     = crc_t_reg;
        rx_buf_next    = rx_buf_reg;
        tx_buf_next    = tx_buf_reg;
        reg_req_next   = reg_req_reg;
        reg_write_next = reg_write_reg;
        reg_addr_next  = reg_addr_reg;
        reg_wdata_next = reg_wdata_reg;
        reg_len_next   = reg_len_reg;
        rdata_next     = rdata_reg;
        want_next      = want_reg;
        tlen_next      = tlen_reg;
        tx_go_next     = 1'b0;
        tx_data_next   = tx_data_reg;
        unique case (state_reg)
            M_HDR:
                if (rx_valid_reg)
                begin
                    // Oversize payloads are counted through but not stored
                    if (idx_reg < 17'(`SRC_RX_BUF_LEN))
                        rx_buf_next[idx_reg[4:0]] = rx_byte_reg;
                    if (idx_reg >= 17'(`SRC_CRC_H_FIRST))
                        crc_t_next = src_crc_step(crc_t_reg, rx_byte_reg, CRC_POLY); // [R7]
                    if ((idx_reg >= 17'(`SRC_CRC_H_FIRST)) && (idx_reg <= 17'(`SRC_CRC_H_LAST)))
                        crc_h_next = src_crc_step(crc_h_reg, rx_byte_reg, CRC_POLY); // [R6]
                    idx_next = idx_reg + 17'h00001;
                    if (((idx_reg == 17'h00000) && (rx_byte_reg != `SRC_PFX0))
                        || ((idx_reg == 17'h00001) && (rx_byte_reg != `SRC_PFX1))) // [R5] [R21]
                        idx_next = 17'h00000;
                    else if ((idx_reg >= 17'(`SRC_HDR_LEN - 1))
                             && (idx_reg == 17'(`SRC_HDR_LEN - 1) + {1'b0, plen})) // [R3]
                        state_next = M_EVAL;
                end
            M_EVAL:
            begin
                idx_next   = 17'h00000;
                crc_h_next = CRC_INIT;
                crc_t_next = CRC_INIT;
                state_next = M_HDR;
                if (hdr_ok && (rd_ok || wr_ok)) // [R21]
                begin
                    reg_req_next   = 1'b1;
                    reg_write_next = wr_ok;
                    reg_addr_next  = {rx_buf_reg[16], rx_buf_reg[17], rx_buf_reg[18], rx_buf_reg[19],
                                      rx_buf_reg[20], rx_buf_reg[21], rx_buf_reg[22], rx_buf_reg[23]}; // [R16]
                    reg_len_next   = wr_ok ? (plen - 16'(`SRC_ADDR_LEN)) : rlen;
                    for (int k = 0; k < `SRC_MAX_DATA; k++)
                    begin
                        reg_wdata_next[8*k +: 8] = (16'(k) < plen - 16'(`SRC_ADDR_LEN))
                                                   ? rx_buf_reg[`SRC_HDR_LEN + `SRC_ADDR_LEN + k] : 8'h00;
                    end
                    want_next  = (rx_buf_reg[8] == `SRC_FLAG_ACK); // [R9]
                    state_next = M_REQ;
                end
            end
            M_REQ:
                if (reg_ack)
                begin
                    reg_req_next = 1'b0;
                    rdata_next   = reg_rdata;
                    state_next   = want_reg ? M_BUILD : M_HDR; // [R9] [R2]
                end
            M_BUILD:
            begin
                tx_buf_next[0]  = `SRC_PFX0; // [R5]
                tx_buf_next[1]  = `SRC_PFX1;
                tx_buf_next[6]  = 8'h00; // [R8]
                tx_buf_next[7]  = 8'h00;
                tx_buf_next[8]  = 8'h00; // [R10]
                tx_buf_next[9]  = 8'h00;
                tx_buf_next[10] = `SRC_CMD_HI; // [R12]
                tx_buf_next[11] = reg_write_reg ? `SRC_CMD_WR_ACK : `SRC_CMD_RD_ACK;
                tx_buf_next[12] = 8'h00; // [R13]
                tx_buf_next[13] = reg_write_reg ? 8'(`SRC_WR_ACK_LEN) : reg_len_reg[7:0];
                tx_buf_next[14] = rx_buf_reg[14]; // [R15]
                tx_buf_next[15] = rx_buf_reg[15];
                for (int k = 0; k < `SRC_MAX_DATA; k++)
                begin
                    tx_buf_next[`SRC_HDR_LEN + k] = reg_write_reg ? 8'h00 : rdata_reg[8*k +: 8]; // [R18] [R20]
                end
                tlen_next  = reg_write_reg ? 5'(`SRC_HDR_LEN + `SRC_WR_ACK_LEN)
                                           : 5'(`SRC_HDR_LEN) + reg_len_reg[4:0];
                idx_next   = 17'(`SRC_CRC_H_FIRST);
                state_next = M_CRC;
            end
            M_CRC:
            begin
                crc_t_next = src_crc_step(crc_t_reg, tx_buf_reg[idx_reg[4:0]], CRC_POLY); // [R7]
                if (idx_reg <= 17'(`SRC_CRC_H_LAST))
                    crc_h_next = src_crc_step(crc_h_reg, tx_buf_reg[idx_reg[4:0]], CRC_POLY); // [R6]
                idx_next = idx_reg + 17'h00001;
                // Payload is never empty, so the header CRC is final here
                if (idx_reg[4:0] == tlen_reg - 5'h01)
                begin
                    tx_buf_next[2] = crc_h_reg[15:8]; // [R4]
                    tx_buf_next[3] = crc_h_reg[7:0];
                    tx_buf_next[4] = crc_t_next[15:8];
                    tx_buf_next[5] = crc_t_next[7:0];
                    idx_next       = 17'h00000;
                    state_next     = M_SEND;
                end
            end
            M_SEND:
                if ((tx_state_reg == TX_IDLE) && !tx_go_reg)
                begin
                    if (idx_reg[4:0] == tlen_reg)
                    begin
                        idx_next   = 17'h00000;
                        crc_h_next = CRC_INIT;
                        crc_t_next = CRC_INIT;
                        state_next = M_HDR;
                    end
                    else
                    begin
                        tx_go_next   = 1'b1; // [R2]
                        tx_data_next = tx_buf_reg[idx_reg[4:0]];
                        idx_next     = idx_reg + 17'h00001;
                    end
                end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg     <= M_HDR;
            idx_reg       <= 17'h00000;
            crc_h_reg     <= CRC_INIT;
            crc_t_reg     <= CRC_INIT;
            rx_buf_reg    <= '{default: 8'h00};
            tx_buf_reg    <= '{default: 8'h00};
            reg_req_reg   <= 1'b0;
            reg_write_reg <= 1'b0;
            reg_addr_reg  <= 64'h0000000000000000;
            reg_wdata_reg <= 64'h0000000000000000;
            reg_len_reg   <= 16'h0000;
            rdata_reg     <= 64'h0000000000000000;
            want_reg      <= 1'b0;
            tlen_reg      <= 5'h00;
            tx_go_reg     <= 1'b0;
            tx_data_reg   <= 8'h00;
        end
        else
        begin
            state_reg     <= state_next;
            idx_reg       <= idx_next;
            crc_h_reg     <= crc_h_next;
            crc_t_reg     <= crc_t_next;
            rx_buf_reg    <= rx_buf_next;
            tx_buf_reg    <= tx_buf_next;
            reg_req_reg   <= reg_req_next;
            reg_write_reg <= reg_write_next;
            reg_addr_reg  <= reg_addr_next;
            reg_wdata_reg <= reg_wdata_next;
            reg_len_reg   <= reg_len_next;
            rdata_reg     <= rdata_next;
            want_reg      <= want_next;
            tlen_reg      <= tlen_next;
            tx_go_reg     <= tx_go_next;
            tx_data_reg   <= tx_data_next;
        end
    end

    assign reg_req   = reg_req_reg;
    assign reg_write = reg_write_reg;
    assign reg_addr  = reg_addr_reg;
    assign reg_wdata = reg_wdata_reg;
    assign reg_len   = reg_len_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_taken;
        (state_reg == M_REQ) && reg_ack;
    endsequence
    sequence s_reply_start;
        state_reg == M_BUILD ##1 state_reg == M_CRC;
    endsequence

    chk_bit_period: assert property ( // [R1]
        (tx_state_reg != tx_state_next) && (tx_state_reg != TX_IDLE) |-> tx_cnt_reg == BIT_LAST)
        else $error("tx bit period wrong");
    chk_eight_bits: assert property ( // [R1]
        (tx_state_reg == TX_DATA) ##1 (tx_state_reg == TX_STOP) |-> $past(tx_bit_reg) == 3'h7)
        else $error("tx char not eight bits");
    chk_no_unsolicited: assert property ( // [R2]
        tx_go_next |-> (state_reg == M_SEND) && want_reg)
        else $error("unsolicited transmit");
    chk_silent_no_ack: assert property ( // [R9]
        s_taken ##0 !want_reg |=> (state_reg == M_HDR) [*3])
        else $error("reply without request");
    chk_req_after_eval: assert property ( // [R21]
        $rose(reg_req_reg) |-> $past(state_reg) == M_EVAL && $past(hdr_ok))
        else $error("request from unchecked frame");
    chk_reply_fields: assert property ( // [R10]
        s_reply_start |-> tx_buf_reg[8] == 8'h00 && tx_buf_reg[9] == 8'h00 && tx_buf_reg[0] == `SRC_PFX0)
        else $error("reply header fields wrong");
    chk_reply_cmd: assert property ( // [R12]
        s_reply_start |-> tx_buf_reg[11] == (reg_write_reg ? `SRC_CMD_WR_ACK : `SRC_CMD_RD_ACK))
        else $error("reply command wrong");
    chk_reply_seq: assert property ( // [R15]
        s_reply_start |-> {tx_buf_reg[14], tx_buf_reg[15]} == {rx_buf_reg[14], rx_buf_reg[15]})
        else $error("reply sequence id changed");
    chk_reply_len: assert property ( // [R18]
        s_reply_start |-> tlen_reg == (reg_write_reg ? 5'd20 : 5'd16 + reg_len_reg[4:0]))
        else $error("reply length wrong");
    chk_prefix_resync: assert property ( // [R5]
        (state_reg == M_HDR) && rx_valid_reg && (idx_reg == 17'h00000) && (rx_byte_reg != `SRC_PFX0)
        |=> idx_reg == 17'h00000)
        else $error("bad prefix not dropped");
endmodule : src_core

/* File: test/src_host.sv */
`include "src_map.svh"
module src_host
    import src_pkg::*;
#(
    parameter int BIT = `SRC_BIT_CYC
)
(
    input  wire logic core_clk,
    output logic      uart_rxd,
    input  wire logic uart_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    src_byte_t     reply_q[$];
    src_byte_t     rx_b;
    logic [15:0]   seq_reg = 16'h0000;

    // ------------------------------------------------------------
    // Host side of the command link
    // ------------------------------------------------------------
    function automatic logic [15:0] crc(input src_byte_t f[$], input int lo, input int hi);
        logic [15:0] c;
        c = `SRC_CRC_INIT;
        for (int i = lo; i <= hi; i++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ f[i][b]) ? `SRC_CRC_POLY : 16'h0000);
        return c;
    endfunction : crc

    task automatic send_byte(input src_byte_t b);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            uart_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
            repeat (BIT - 1) @(posedge core_clk);
        end
    endtask : send_byte

    // Old replies are dropped when a new command goes out
    task automatic send_frame(input src_byte_t flg, input src_byte_t cmd, input logic [63:0] addr,
                              input src_byte_t dat[$], input bit bad);
        src_byte_t   f[$];
        logic [15:0] c;
        reply_q.delete();
        f = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, flg, 8'h01, 8'h08, cmd};
        f = {f, 8'h00, 8'(8 + dat.size()), seq_reg[15:8], seq_reg[7:0]};
        for (int i = 7; i >= 0; i--)
            f.push_back(addr[8 * i +: 8]);
        f = {f, dat};
        c = crc(f, 6, 15);
        f[2] = c[15:8];
        f[3] = c[7:0];
        c = crc(f, 6, f.size() - 1);
        f[4] = c[15:8] ^ (bad ? 8'hFF : 8'h00);
        f[5] = c[7:0];
        seq_reg = seq_reg + 16'h0001;
        foreach (f[i])
            send_byte(f[i]);
    endtask : send_frame

    initial
    begin
        uart_rxd = 1'b1;
        forever
        begin
            @(negedge uart_txd);
            repeat (BIT / 2) @(posedge core_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge core_clk);
                rx_b[i] = uart_txd;
            end
            repeat (BIT) @(posedge core_clk);
            reply_q.push_back(rx_b);
        end
    end
endmodule : src_host

/* File: test/src_core_tb_top.sv */
`include "src_map.svh"
`define CHK(a, e) check_val(64'(a), 64'(e))
module src_core_tb_top
    import src_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] ADDR = 64'h0000_0000_2000_0200;
    // Short bit time keeps the run brief
    localparam int          SIM_BIT = 32;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        uart_rxd;
    logic        uart_txd;
    logic        reg_req;
    logic        reg_write;
    logic [63:0] reg_addr;
    logic [63:0] reg_wdata;
    logic [15:0] reg_len;
    logic        reg_ack = 1'b0;
    logic [63:0] reg_rdata = 64'h0;
    int          comparisons = 0;
    int          miscompares = 0;

    always #2 core_clk = ~core_clk;

    src_core #(.BIT_CYC(SIM_BIT)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .uart_rxd(uart_rxd), .uart_txd(uart_txd),
        .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_len(reg_len), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
    src_host #(.BIT(SIM_BIT)) u_host (.core_clk(core_clk), .uart_rxd(uart_rxd), .uart_txd(uart_txd));

    // ------------------------------------------------------------
    // Shared checks and waits
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check_val(input logic [63:0] a, input logic [63:0] e);
        comparisons++;
        if (a !== e)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, e);
        end
    endtask : check_val

    // need 0 waits for a request, otherwise for that many reply bytes
    task automatic wait_for(input int need, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while ((need == 0 ? reg_req !== 1'b1 : u_host.reply_q.size() < need) && n < lim);
        if (n == lim)
        begin
            miscompares++;
            complete_run();
        end
    endtask : wait_for

    task automatic serve(input logic wr, input logic [63:0] wd, input logic [15:0] len, input logic [63:0] rd);
        wait_for(0, 5000);
        `CHK(reg_write, wr);
        `CHK(reg_addr, ADDR);
        if (wr)
            `CHK(reg_wdata, wd);
        `CHK(reg_len, len);
        @(posedge core_clk);
        reg_ack <= 1'b1;
        reg_rdata <= rd;
        @(posedge core_clk);
        reg_ack <= 1'b0;
        @(negedge core_clk);
        `CHK(reg_req, 1'b0);
    endtask : serve

    task automatic check_reply(input src_byte_t cmd, input src_byte_t pay[$], input logic [15:0] seq);
        src_byte_t   e[$];
        logic [15:0] c;
        wait_for(16 + pay.size(), 20000);
        e = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, cmd};
        e = {e, 8'h00, 8'(pay.size()), seq[15:8], seq[7:0], pay};
        c = u_host.crc(e, 6, 15);
        {e[2], e[3]} = c;
        c = u_host.crc(e, 6, e.size() - 1);
        {e[4], e[5]} = c;
        foreach (e[i])
            `CHK(u_host.reply_q[i], e[i]);
    endtask : check_reply

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic check_reset();
        repeat (16) @(posedge core_clk);
        `CHK({uart_txd, reg_req, reg_len}, 18'h20000);
        reset_n <= 1'b1;
        @(posedge core_clk);
    endtask : check_reset

    task automatic write_quiet();
        u_host.send_frame(8'h00, 8'h02, ADDR, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b0);
        serve(1'b1, 64'h44332211, 16'h0004, 64'h0);
        repeat (3 * SIM_BIT) @(negedge core_clk);
        `CHK(u_host.reply_q.size(), 0);
    endtask : write_quiet

    task automatic read_reply();
        logic [15:0] s;
        s = u_host.seq_reg;
        u_host.send_frame(8'h40, 8'h00, ADDR, {8'h00, 8'h00, 8'h00, 8'h04}, 1'b0);
        serve(1'b0, 64'h0, 16'h0004, 64'hA1B2C3D4);
        check_reply(8'h01, {8'hD4, 8'hC3, 8'hB2, 8'hA1}, s);
    endtask : read_reply

    task automatic bad_crc();
        u_host.send_frame(8'h40, 8'h02, ADDR, {8'h5A}, 1'b1);
        repeat (3 * SIM_BIT) @(negedge core_clk);
        `CHK({reg_req, 32'(u_host.reply_q.size())}, 33'h0);
    endtask : bad_crc

    task automatic write_reply();
        logic [15:0] s;
        s = u_host.seq_reg;
        u_host.send_frame(8'h40, 8'h02, ADDR, {8'h5A}, 1'b0);
        serve(1'b1, 64'h5A, 16'h0001, 64'h0);
        check_reply(8'h03, {8'h00, 8'h00, 8'h00, 8'h00}, s);
    endtask : write_reply

    initial
    begin
        check_reset();
        write_quiet();
        read_reply();
        bad_crc();
        write_reply();
        complete_run();
    end
endmodule : src_core_tb_top
